// >>> core/csms_consts.svh
/*
 constants of the channel switch mode select block: register addresses,
 field positions, reset values and mode codes.
 assumes inclusion by bare name from the package and the design.
*/
// Function
// - fast enable low means channels off, standby
// - fast mode 00 quad, 01 dual, 10 single
// - fast mode write of 11 keeps old mode
// - quad uses low two bits, whole source
// - dual picks channel pair, even low lanes
// - single picks one of sixteen channels
// - slow enable low connects no slow input
// - slow mode 00 quad, 01 dual, 10 single
// - slow mode write of 11 keeps old mode
// - slow quad connects whole source to common
// - slow dual low codes route An and Cn
// - slow single picks one of sixteen lines
`ifndef CSMS_CONSTS_SVH
`define CSMS_CONSTS_SVH
`define CSMS_ADDR_FAST   8'h00
`define CSMS_ADDR_SLOW   8'h01
`define CSMS_RESET_VAL   7'h40
`define CSMS_EN_BIT      6
`define CSMS_MODE_HI     5
`define CSMS_MODE_LO     4
`define CSMS_PICK_HI     3
`define CSMS_PICK_LO     0
`define CSMS_MODE_QUAD   2'h0
`define CSMS_MODE_DUAL   2'h1
`define CSMS_MODE_SINGLE 2'h2
`define CSMS_MODE_BAD    2'h3
`define CSMS_ONE_HOT     16'h0001
`define CSMS_ZERO16      16'h0000
`define CSMS_ZERO8       8'h00
`endif

// >>> core/csms_pkg.sv
/*
 types of the channel switch mode select block.
 assumes csms_consts.svh is reachable on the include path.
*/
`include "csms_consts.svh"
package csms_pkg;
	typedef struct packed {
		logic       on;
		logic [1:0] mode;
		logic [3:0] pick;
	} csms_route_s;
	typedef struct packed {
		logic        rst_meta;
		logic        rst_sync;
		csms_route_s fast;
		csms_route_s slow;
		logic [7:0]  rd_data;
		logic [15:0] fast_lane0;
		logic [15:0] fast_lane1;
		logic [15:0] fast_lane2;
		logic [15:0] fast_lane3;
		logic [15:0] slow_line0;
		logic [15:0] slow_line1;
		logic [15:0] slow_line2;
		logic [15:0] slow_line3;
	} csms_state_s;
endpackage

// >>> core/csms_top.sv
/*
 register pair and route decode of the channel switch mode select block.
 assumes a serial control front end, on clk, gives byte write and read
 strobes with an 8-bit register address.  each select output is a 16-bit
 one-hot vector over sources A0..D3 (bit 4*letter+number); all zero means
 the lane or common line is disconnected.
*/
`timescale 1ns/1ps
`include "csms_consts.svh"
module csms_top
	import csms_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wr_data,
	output logic      [7:0]  rd_data,
	output logic             fast_path_on,
	output logic      [15:0] fast_lane0_sel,
	output logic      [15:0] fast_lane1_sel,
	output logic      [15:0] fast_lane2_sel,
	output logic      [15:0] fast_lane3_sel,
	output logic      [15:0] slow_common_port0,
	output logic      [15:0] slow_common_port1,
	output logic      [15:0] slow_common_port2,
	output logic      [15:0] slow_common_port3
);

////////////////////////////////////////////////////////////////////////////
// helpers

function automatic csms_route_s csms_write(csms_route_s old,
		logic [7:0] d);
	csms_route_s r;
	r.on   = d[`CSMS_EN_BIT];
	r.pick = d[`CSMS_PICK_HI:`CSMS_PICK_LO];
	if (d[`CSMS_MODE_HI:`CSMS_MODE_LO] == `CSMS_MODE_BAD) begin
		r.mode = old.mode;
	end else begin
		r.mode = d[`CSMS_MODE_HI:`CSMS_MODE_LO];
	end
	return r;
endfunction

function automatic logic [15:0] csms_hot(logic [1:0] letter,
		logic [1:0] num);
	return `CSMS_ONE_HOT << {letter, num};
endfunction

////////////////////////////////////////////////////////////////////////////
// state

csms_state_s st_r;
csms_state_s st_nxt;
logic        rst_n_int;

assign rst_n_int = st_r.rst_sync;

// one register process; the release synchroniser lives in the state too
always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		st_r.rst_meta   <= 1'b0;
		st_r.rst_sync   <= 1'b0;
		st_r.fast       <= `CSMS_RESET_VAL;
		st_r.slow       <= `CSMS_RESET_VAL;
		st_r.rd_data    <= `CSMS_ZERO8;
		st_r.fast_lane0 <= `CSMS_ZERO16;
		st_r.fast_lane1 <= `CSMS_ZERO16;
		st_r.fast_lane2 <= `CSMS_ZERO16;
		st_r.fast_lane3 <= `CSMS_ZERO16;
		st_r.slow_line0 <= `CSMS_ZERO16;
		st_r.slow_line1 <= `CSMS_ZERO16;
		st_r.slow_line2 <= `CSMS_ZERO16;
		st_r.slow_line3 <= `CSMS_ZERO16;
	end else begin
		st_r.rst_meta   <= st_nxt.rst_meta;
		st_r.rst_sync   <= st_nxt.rst_sync;
		st_r.fast       <= st_nxt.fast;
		st_r.slow       <= st_nxt.slow;
		st_r.rd_data    <= st_nxt.rd_data;
		st_r.fast_lane0 <= st_nxt.fast_lane0;
		st_r.fast_lane1 <= st_nxt.fast_lane1;
		st_r.fast_lane2 <= st_nxt.fast_lane2;
		st_r.fast_lane3 <= st_nxt.fast_lane3;
		st_r.slow_line0 <= st_nxt.slow_line0;
		st_r.slow_line1 <= st_nxt.slow_line1;
		st_r.slow_line2 <= st_nxt.slow_line2;
		st_r.slow_line3 <= st_nxt.slow_line3;
	end
end

////////////////////////////////////////////////////////////////////////////
// register access and decode

always_comb begin
	logic [1:0] lt;
	logic [1:0] nm;
	lt = 2'h0;
	nm = 2'h0;
	st_nxt = st_r;
	st_nxt.rst_meta = 1'b1;
	st_nxt.rst_sync = st_r.rst_meta;
	// register writes; a write leaves the other register untouched
	if (wr_en && addr == `CSMS_ADDR_FAST) begin
		st_nxt.fast = csms_write(st_r.fast, wr_data);
	end
	if (wr_en && addr == `CSMS_ADDR_SLOW) begin
		st_nxt.slow = csms_write(st_r.slow, wr_data);
	end
	// reads; unmapped addresses read zero
	if (rd_en) begin
		case (addr)
		`CSMS_ADDR_FAST: st_nxt.rd_data = {1'b0, st_r.fast};
		`CSMS_ADDR_SLOW: st_nxt.rd_data = {1'b0, st_r.slow};
		default:         st_nxt.rd_data = `CSMS_ZERO8;
		endcase
	end
	// fast path decode from stored fields
	st_nxt.fast_lane0 = `CSMS_ZERO16;
	st_nxt.fast_lane1 = `CSMS_ZERO16;
	st_nxt.fast_lane2 = `CSMS_ZERO16;
	st_nxt.fast_lane3 = `CSMS_ZERO16;
	if (st_r.fast.on) begin
		case (st_r.fast.mode)
		`CSMS_MODE_QUAD: begin
			lt = st_r.fast.pick[1:0];
			st_nxt.fast_lane0 = csms_hot(lt, 2'h0);
			st_nxt.fast_lane1 = csms_hot(lt, 2'h1);
			st_nxt.fast_lane2 = csms_hot(lt, 2'h2);
			st_nxt.fast_lane3 = csms_hot(lt, 2'h3);
		end
		`CSMS_MODE_DUAL: begin
			lt = st_r.fast.pick[2:1];
			nm = {st_r.fast.pick[0], 1'b0};
			st_nxt.fast_lane0 = csms_hot(lt, nm);
			st_nxt.fast_lane1 = csms_hot(lt, nm);
			st_nxt.fast_lane2 = csms_hot(lt, nm | 2'h1);
			st_nxt.fast_lane3 = csms_hot(lt, nm | 2'h1);
		end
		`CSMS_MODE_SINGLE: begin
			lt = st_r.fast.pick[3:2];
			nm = st_r.fast.pick[1:0];
			st_nxt.fast_lane0 = csms_hot(lt, nm);
			st_nxt.fast_lane1 = csms_hot(lt, nm);
			st_nxt.fast_lane2 = csms_hot(lt, nm);
			st_nxt.fast_lane3 = csms_hot(lt, nm);
		end
		default: begin
			st_nxt.fast_lane0 = `CSMS_ZERO16;
		end
		endcase
	end
	// slow path decode from stored fields
	st_nxt.slow_line0 = `CSMS_ZERO16;
	st_nxt.slow_line1 = `CSMS_ZERO16;
	st_nxt.slow_line2 = `CSMS_ZERO16;
	st_nxt.slow_line3 = `CSMS_ZERO16;
	if (st_r.slow.on) begin
		case (st_r.slow.mode)
		`CSMS_MODE_QUAD: begin
			lt = st_r.slow.pick[1:0];
			st_nxt.slow_line0 = csms_hot(lt, 2'h0);
			st_nxt.slow_line1 = csms_hot(lt, 2'h1);
			st_nxt.slow_line2 = csms_hot(lt, 2'h2);
			st_nxt.slow_line3 = csms_hot(lt, 2'h3);
		end
		`CSMS_MODE_DUAL: begin
			// low codes A and C, high codes B and D
			lt = {1'b0, st_r.slow.pick[2]};
			nm = st_r.slow.pick[1:0];
			st_nxt.slow_line0 = csms_hot(lt, nm);
			st_nxt.slow_line1 = csms_hot(lt, nm);
			st_nxt.slow_line2 = csms_hot(lt | 2'h2, nm);
			st_nxt.slow_line3 = csms_hot(lt | 2'h2, nm);
		end
		`CSMS_MODE_SINGLE: begin
			lt = st_r.slow.pick[3:2];
			nm = st_r.slow.pick[1:0];
			st_nxt.slow_line0 = csms_hot(lt, nm);
			st_nxt.slow_line1 = csms_hot(lt, nm);
			st_nxt.slow_line2 = csms_hot(lt, nm);
			st_nxt.slow_line3 = csms_hot(lt, nm);
		end
		default: begin
			st_nxt.slow_line0 = `CSMS_ZERO16;
		end
		endcase
	end

	// hold all but the synchroniser at reset until the synced release
	if (!rst_n_int) begin
		st_nxt.fast       = `CSMS_RESET_VAL;
		st_nxt.slow       = `CSMS_RESET_VAL;
		st_nxt.rd_data    = `CSMS_ZERO8;
		st_nxt.fast_lane0 = `CSMS_ZERO16;
		st_nxt.fast_lane1 = `CSMS_ZERO16;
		st_nxt.fast_lane2 = `CSMS_ZERO16;
		st_nxt.fast_lane3 = `CSMS_ZERO16;
		st_nxt.slow_line0 = `CSMS_ZERO16;
		st_nxt.slow_line1 = `CSMS_ZERO16;
		st_nxt.slow_line2 = `CSMS_ZERO16;
		st_nxt.slow_line3 = `CSMS_ZERO16;
	end
end

////////////////////////////////////////////////////////////////////////////
// outputs

assign rd_data           = st_r.rd_data;
assign fast_path_on      = st_r.fast.on;
assign fast_lane0_sel    = st_r.fast_lane0;
assign fast_lane1_sel    = st_r.fast_lane1;
assign fast_lane2_sel    = st_r.fast_lane2;
assign fast_lane3_sel    = st_r.fast_lane3;
assign slow_common_port0 = st_r.slow_line0;
assign slow_common_port1 = st_r.slow_line1;
assign slow_common_port2 = st_r.slow_line2;
assign slow_common_port3 = st_r.slow_line3;

endmodule

// >>> tb/csms_chk_sva.sv
/* assertions on the csms_top select outputs.
 assumes a bind into csms_top and a single clock. */
`timescale 1ns/1ps
module csms_chk (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        fast_path_on,
	input wire logic [15:0] fast_lane0_sel,
	input wire logic [15:0] fast_lane1_sel,
	input wire logic [15:0] fast_lane2_sel,
	input wire logic [15:0] fast_lane3_sel,
	input wire logic [15:0] slow_common_port0,
	input wire logic [15:0] slow_common_port1,
	input wire logic [15:0] slow_common_port2,
	input wire logic [15:0] slow_common_port3
);
	wire [15:0] f0 = fast_lane0_sel, f1 = fast_lane1_sel;
	wire [15:0] f2 = fast_lane2_sel, f3 = fast_lane3_sel;
	wire [15:0] s0 = slow_common_port0, s1 = slow_common_port1;
	wire [15:0] s2 = slow_common_port2, s3 = slow_common_port3;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////
	property p_off; !fast_path_on [*2] |-> !(f0|f1|f2|f3); endproperty
	a_off: assert property (p_off) else $error("lane on when off");
	property p_shape; f1==f0 || f1==f0<<1; endproperty
	a_shape: assert property (p_shape) else $error("lane shape");
	property p_quad; f1==f0<<1 |-> f3==f0<<3 && !(f0&16'heeee); endproperty
	a_quad: assert property (p_quad) else $error("quad lanes");
	property p_dual; f0==f1 && f2!=f0 |->
		f2==f0<<1 && f3==f2 && !(f0&16'haaaa); endproperty
	a_dual: assert property (p_dual) else $error("dual lanes");
	property p_single; f3==f0 |-> f1==f0 && f2==f0 && $onehot0(f0); endproperty
	a_single: assert property (p_single) else $error("single lanes");
	property p_squad; s1==s0<<1 |-> s3==s0<<3 && !(s0&16'heeee); endproperty
	a_squad: assert property (p_squad) else $error("slow quad");
	property p_sdual; s0==s1 && s2!=s0 |->
		s2==s0<<8 && s3==s2 && !(s0&16'hff00); endproperty
	a_sdual: assert property (p_sdual) else $error("slow dual");
	property p_ssing; s3==s0 |-> s1==s0 && s2==s0 && $onehot0(s0); endproperty
	a_ssing: assert property (p_ssing) else $error("slow single");
	c_off: cover property (!fast_path_on);
	c_dual: cover property (f0==f1 && f2!=f0);
	c_sdual: cover property (s0==s1 && s2!=s0);
endmodule
bind csms_top csms_chk u_chk (.clk(clk), .reset_n(reset_n),
	.fast_path_on(fast_path_on), .fast_lane0_sel(fast_lane0_sel),
	.fast_lane1_sel(fast_lane1_sel), .fast_lane2_sel(fast_lane2_sel),
	.fast_lane3_sel(fast_lane3_sel), .slow_common_port0(slow_common_port0),
	.slow_common_port1(slow_common_port1),
	.slow_common_port2(slow_common_port2),
	.slow_common_port3(slow_common_port3));

// >>> tb/test_channel_switch_mode_select.sv
/* bench of csms_top against a register model.
 assumes the design files are compiled first. */
`timescale 1ns/1ps
module test_channel_switch_mode_select;
	logic        clk, reset_n, wr_en, rd_en, on;
	logic [7:0]  addr, wr_data, rd_data;
	wire  [15:0] fl [4], sl [4];
	logic [6:0]  m [2];
	int          num_errors, comparisons, r, i, j;
	integer      seed;
	csms_top uut (.clk(clk), .reset_n(reset_n), .wr_en(wr_en),
		.rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
		.fast_path_on(on), .fast_lane0_sel(fl[0]), .fast_lane1_sel(fl[1]),
		.fast_lane2_sel(fl[2]), .fast_lane3_sel(fl[3]),
		.slow_common_port0(sl[0]), .slow_common_port1(sl[1]),
		.slow_common_port2(sl[2]), .slow_common_port3(sl[3]));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	////////////////////////////////////////
	task chk(input logic [15:0] g, e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %0t %h %h", $time, g, e);
		end
	endtask
	function logic [15:0] ex(input logic [6:0] v, input int s, k);
		int b;
		b = v[5:4] == 2'h0 ? 4 * v[1:0] + k : v[5:4] == 2'h2 ? v[3:0]
			: s ? k / 2 * 8 + v[2] * 4 + v[1:0] : v[2:0] * 2 + k / 2;
		return v[6] ? 16'h0001 << b : 16'h0000;
	endfunction
	task wr(input logic [7:0] a, d);
		@(posedge clk);
		{wr_en, addr, wr_data} <= {1'b1, a, d};
		@(posedge clk);
		wr_en <= 1'b0;
		if (a < 8'h02)
			m[a[0]] = {d[6], d[5:4] == 2'h3 ? m[a[0]][5:4] : d[5:4],
				d[3:0]};
	endtask
	task verify(input logic [7:0] a);
		@(posedge clk);
		{rd_en, addr} <= {1'b1, a};
		@(posedge clk);
		rd_en <= 1'b0;
		@(posedge clk);
		#1;
		chk({8'h00, rd_data}, a < 8'h02 ? {9'h000, m[a[0]]} : 16'h0000);
		chk({15'h0000, on}, {15'h0000, m[0][6]});
		for (j = 0; j < 4; j++) begin
			chk(fl[j], ex(m[0], 0, j));
			chk(sl[j], ex(m[1], 1, j));
		end
	endtask
	task conclude;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		{reset_n, wr_en, rd_en, addr, wr_data} = 19'h0_0000;
		seed = 78;
		m[0] = 7'h40;
		m[1] = 7'h40;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		verify(8'h00);
		for (i = 0; i < 128; i++) begin
			wr({7'h00, i[0]}, {2'b11, i[2:1], i[6:3]});
			verify({7'h00, i[0]});
		end
		for (i = 0; i < 4; i++) begin
			wr({7'h00, i[0]}, i[1] ? 8'h7b : 8'h26);
			verify({7'h00, i[0]});
		end
		for (i = 0; i < 80; i++) begin
			r = $random(seed);
			wr({r[9], 6'h00, r[8]}, r[7:0]);
			verify({r[11], 6'h00, r[10]});
		end
		conclude;
	end
endmodule
